// ---- sweep_device.sv ----
// sweep_device: sweep parameter registers and autonomous sweep sequencer
// assumes: host on sweep_reg_if.dev, front end answers each measurement
`timescale 1ns/1ps
module sweep_device (
    input  wire logic                         i_clk_sys,
    input  wire logic                         i_rst_n,
    sweep_reg_if.dev                          bus,
    input  wire logic                         i_meas_done,
    input  wire logic [sweep_pkg::RES_W-1:0]  i_meas_real,
    input  wire logic [sweep_pkg::RES_W-1:0]  i_meas_imag,
    output logic                              o_meas_start,
    output logic [sweep_pkg::PHASE_W-1:0]     o_dds_phase,
    output logic [sweep_pkg::CODE_W-1:0]      o_freq_code,
    output logic                              o_sweep_busy
);

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETTLE = 3'b001,
        ST_MEAS   = 3'b010,
        ST_STEP   = 3'b011,
        ST_DONE   = 3'b100
    } sweep_state_t;
    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [sweep_pkg::CODE_W-1:0]  start_code_ff;
    logic [sweep_pkg::CODE_W-1:0]  step_code_ff;
    logic [sweep_pkg::COUNT_W-1:0] count_ff;
    logic [sweep_pkg::COUNT_W-1:0] settle_ff;
    logic [sweep_pkg::RES_W-1:0]   real_ff;
    logic [sweep_pkg::RES_W-1:0]   imag_ff;
    logic                          valid_ff;
    logic                          ack_ff;
    logic [7:0]                    rdata_ff;
    logic [7:0]                    nxt_rdata;
    logic                          wr_hit;
    logic                          rd_hit;
    logic                          cmd_start;
    logic                          cmd_standby;
    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    sweep_state_t                  state_ff;
    logic [sweep_pkg::CODE_W-1:0]  freq_ff;
    logic [sweep_pkg::COUNT_W-1:0] idx_ff;
    logic [sweep_pkg::COUNT_W-1:0] settle_cnt_ff;
    logic [sweep_pkg::PRE_W-1:0]   pre_ff;
    logic [sweep_pkg::PHASE_W-1:0] phase_ff;
    logic                          cycle_tick;
    logic [sweep_pkg::PHASE_W:0]   phase_sum;
    logic                          meas_start_ff;

    assign wr_hit      = bus.req & bus.wr;
    assign rd_hit      = bus.req & ~bus.wr;
    assign cmd_start   = wr_hit && (bus.addr == sweep_pkg::ADDR_CTRL)
                         && (bus.wdata[7:4] == sweep_pkg::CMD_START);
    assign cmd_standby = wr_hit && (bus.addr == sweep_pkg::ADDR_CTRL)
                         && (bus.wdata[7:4] == sweep_pkg::CMD_STANDBY);
    // ------------------------------------------------------------------
    // parameter register writes
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            start_code_ff <= sweep_pkg::CODE_RST;
        end else if (wr_hit) begin
            if (bus.addr == sweep_pkg::ADDR_START_HI) begin
                start_code_ff[23:16] <= bus.wdata;
            end else if (bus.addr == sweep_pkg::ADDR_START_MID) begin
                start_code_ff[15:8] <= bus.wdata;
            end else if (bus.addr == sweep_pkg::ADDR_START_LO) begin
                start_code_ff[7:0] <= bus.wdata;
            end
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            step_code_ff <= sweep_pkg::CODE_RST;
        end else if (wr_hit) begin
            if (bus.addr == sweep_pkg::ADDR_STEP_HI) begin
                step_code_ff[23:16] <= bus.wdata;
            end else if (bus.addr == sweep_pkg::ADDR_STEP_MID) begin
                step_code_ff[15:8] <= bus.wdata;
            end else if (bus.addr == sweep_pkg::ADDR_STEP_LO) begin
                step_code_ff[7:0] <= bus.wdata;
            end
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff  <= sweep_pkg::COUNT_RST;
            settle_ff <= sweep_pkg::SETTLE_RST;
        end else if (wr_hit) begin
            // 9-bit point count, upper bit in 0x88
            if (bus.addr == sweep_pkg::ADDR_COUNT_HI) begin
                count_ff[8] <= bus.wdata[0];
            end else if (bus.addr == sweep_pkg::ADDR_COUNT_LO) begin
                count_ff[7:0] <= bus.wdata;
            end else if (bus.addr == sweep_pkg::ADDR_SETTLE_HI) begin
                settle_ff[8] <= bus.wdata[0];
            end else if (bus.addr == sweep_pkg::ADDR_SETTLE_LO) begin
                settle_ff[7:0] <= bus.wdata;
            end
        end
    end
    // ------------------------------------------------------------------
    // read mux and link answer
    // ------------------------------------------------------------------
    always_comb begin
        if (bus.addr == sweep_pkg::ADDR_START_HI) begin
            nxt_rdata = start_code_ff[23:16];
        end else if (bus.addr == sweep_pkg::ADDR_START_MID) begin
            nxt_rdata = start_code_ff[15:8];
        end else if (bus.addr == sweep_pkg::ADDR_START_LO) begin
            nxt_rdata = start_code_ff[7:0];
        end else if (bus.addr == sweep_pkg::ADDR_STEP_HI) begin
            nxt_rdata = step_code_ff[23:16];
        end else if (bus.addr == sweep_pkg::ADDR_STEP_MID) begin
            nxt_rdata = step_code_ff[15:8];
        end else if (bus.addr == sweep_pkg::ADDR_STEP_LO) begin
            nxt_rdata = step_code_ff[7:0];
        end else if (bus.addr == sweep_pkg::ADDR_COUNT_HI) begin
            nxt_rdata = {7'h00, count_ff[8]};
        end else if (bus.addr == sweep_pkg::ADDR_COUNT_LO) begin
            nxt_rdata = count_ff[7:0];
        end else if (bus.addr == sweep_pkg::ADDR_SETTLE_HI) begin
            nxt_rdata = {7'h00, settle_ff[8]};
        end else if (bus.addr == sweep_pkg::ADDR_SETTLE_LO) begin
            nxt_rdata = settle_ff[7:0];
        end else if (bus.addr == sweep_pkg::ADDR_STATUS) begin
            nxt_rdata = {5'h00, state_ff == ST_DONE, valid_ff, o_sweep_busy};
        end else if (bus.addr == sweep_pkg::ADDR_REAL_HI) begin
            nxt_rdata = real_ff[15:8];
        end else if (bus.addr == sweep_pkg::ADDR_REAL_LO) begin
            nxt_rdata = real_ff[7:0];
        end else if (bus.addr == sweep_pkg::ADDR_IMAG_HI) begin
            nxt_rdata = imag_ff[15:8];
        end else if (bus.addr == sweep_pkg::ADDR_IMAG_LO) begin
            nxt_rdata = imag_ff[7:0];
        end else begin
            nxt_rdata = 8'h00;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            ack_ff <= bus.req;
            if (rd_hit) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end
    assign bus.ack   = ack_ff;
    assign bus.rdata = rdata_ff;
    // ------------------------------------------------------------------
    // excitation phase accumulator
    // ------------------------------------------------------------------
    // phase steps once per four clocks, so fout tracks the clock
    assign phase_sum  = {1'b0, phase_ff} + {4'h0, freq_ff};
    assign cycle_tick = (pre_ff == '1) && phase_sum[sweep_pkg::PHASE_W];
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pre_ff   <= '0;
            phase_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 2'd1;
            if (state_ff == ST_IDLE) begin
                phase_ff <= '0;
            end else if (pre_ff == '1) begin
                phase_ff <= phase_sum[sweep_pkg::PHASE_W-1:0];
            end
        end
    end
    // ------------------------------------------------------------------
    // sweep sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff      <= ST_IDLE;
            freq_ff       <= sweep_pkg::CODE_RST;
            idx_ff        <= '0;
            settle_cnt_ff <= sweep_pkg::SETTLE_RST;
            meas_start_ff <= 1'b0;
        end else begin
            meas_start_ff <= 1'b0;
            if (cmd_standby) begin
                state_ff <= ST_IDLE;
            end else if (cmd_start) begin
                state_ff      <= ST_SETTLE;
                freq_ff       <= start_code_ff;
                idx_ff        <= '0;
                settle_cnt_ff <= settle_ff;
            end else begin
                case (state_ff)
                    ST_SETTLE: begin
                        if (cycle_tick) begin
                            if (settle_cnt_ff == '0) begin
                                state_ff      <= ST_MEAS;
                                meas_start_ff <= 1'b1;
                            end else begin
                                settle_cnt_ff <= settle_cnt_ff - 9'd1;
                            end
                        end
                    end
                    ST_MEAS: begin
                        if (i_meas_done) begin
                            state_ff <= (idx_ff >= count_ff) ? ST_DONE
                                                             : ST_STEP;
                        end
                    end
                    ST_STEP: begin
                        freq_ff       <= freq_ff + step_code_ff;
                        idx_ff        <= idx_ff + 9'd1;
                        settle_cnt_ff <= settle_ff;
                        state_ff      <= ST_SETTLE;
                    end
                    default: state_ff <= state_ff;
                endcase
            end
        end
    end
    // ------------------------------------------------------------------
    // result registers and valid flag
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            real_ff <= sweep_pkg::RES_RST;
            imag_ff <= sweep_pkg::RES_RST;
        end else if (state_ff == ST_MEAS && i_meas_done) begin
            real_ff <= i_meas_real;
            imag_ff <= i_meas_imag;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            valid_ff <= 1'b0;
        end else if (state_ff == ST_MEAS && i_meas_done) begin
            // set wins over the read clear
            valid_ff <= 1'b1;
        end else if (cmd_start
                     || (rd_hit && bus.addr == sweep_pkg::ADDR_IMAG_LO)) begin
            valid_ff <= 1'b0;
        end
    end
    assign o_meas_start = meas_start_ff;
    assign o_dds_phase  = phase_ff;
    assign o_freq_code  = freq_ff;
    assign o_sweep_busy = (state_ff != ST_IDLE) && (state_ff != ST_DONE);

endmodule // sweep_device

// ---- sweep_pkg.sv ----
// sweep_pkg: shared constants of the impedance sweep register block
// assumes: one 20 MHz system clock shared by both ends of the link
package sweep_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int CODE_W  = 24;
    localparam int COUNT_W = 9;
    localparam int RES_W   = 16;
    localparam int PHASE_W = 27;
    localparam int PRE_W   = 2;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL      = 8'h80;
    localparam logic [7:0] ADDR_START_HI  = 8'h82;
    localparam logic [7:0] ADDR_START_MID = 8'h83;
    localparam logic [7:0] ADDR_START_LO  = 8'h84;
    localparam logic [7:0] ADDR_STEP_HI   = 8'h85;
    localparam logic [7:0] ADDR_STEP_MID  = 8'h86;
    localparam logic [7:0] ADDR_STEP_LO   = 8'h87;
    localparam logic [7:0] ADDR_COUNT_HI  = 8'h88;
    localparam logic [7:0] ADDR_COUNT_LO  = 8'h89;
    localparam logic [7:0] ADDR_SETTLE_HI = 8'h8a;
    localparam logic [7:0] ADDR_SETTLE_LO = 8'h8b;
    localparam logic [7:0] ADDR_STATUS    = 8'h8f;
    localparam logic [7:0] ADDR_REAL_HI   = 8'h94;
    localparam logic [7:0] ADDR_REAL_LO   = 8'h95;
    localparam logic [7:0] ADDR_IMAG_HI   = 8'h96;
    localparam logic [7:0] ADDR_IMAG_LO   = 8'h97;

    // ------------------------------------------------------------------
    // control commands (upper nibble of control) and status bits
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_START   = 4'h3;
    localparam logic [3:0] CMD_STANDBY = 4'hb;
    localparam int         STAT_BUSY   = 0;
    localparam int         STAT_VALID  = 1;
    localparam int         STAT_DONE   = 2;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0]  CODE_RST   = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_RST  = 9'h000;
    localparam logic [COUNT_W-1:0] SETTLE_RST = 9'h000;
    localparam logic [COUNT_W-1:0] SETTLE_USE = 9'h00f;
    localparam logic [RES_W-1:0]   RES_RST    = 16'h0000;
    localparam int                 WR_ITEMS   = 11;

endpackage

// ---- sweep_reg_if.sv ----
// sweep_reg_if: byte register link between sweep host and sweep device
// assumes: both ends clocked by the same system clock
`timescale 1ns/1ps
interface sweep_reg_if;
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;

    modport dev  (input req, wr, addr, wdata, output ack, rdata);
    modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface

// ---- sweep_host.sv ----
// sweep_host: host end that programs a sweep and collects its results
// assumes: device on sweep_reg_if.host, one request in flight at a time
`timescale 1ns/1ps
module sweep_host (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst_n,
    sweep_reg_if.host                          bus,
    input  wire logic                          i_go,
    input  wire logic [sweep_pkg::CODE_W-1:0]  i_start_code,
    input  wire logic [sweep_pkg::CODE_W-1:0]  i_step_code,
    input  wire logic [sweep_pkg::COUNT_W-1:0] i_point_count,
    input  wire logic [sweep_pkg::COUNT_W-1:0] i_settle_cycles,
    output logic                               o_busy,
    output logic [sweep_pkg::RES_W-1:0]        o_result_real,
    output logic [sweep_pkg::RES_W-1:0]        o_result_imag,
    output logic                               o_result_valid,
    output logic                               o_sweep_done
);

    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_WRITE = 3'b001,
        H_POLL  = 3'b010,
        H_READ  = 3'b011,
        H_FIN   = 3'b100
    } host_state_t;

    host_state_t   state_ff;
    logic [3:0]    idx_ff;
    logic          pend_ff;
    logic          req_ff;
    logic          wr_ff;
    logic [7:0]    addr_ff;
    logic [7:0]    wdata_ff;
    logic [15:0]   item;
    logic [31:0]   res_ff;
    logic          valid_ff;
    logic          done_ff;

    // ------------------------------------------------------------------
    // programming table: {address, data}
    // ------------------------------------------------------------------
    function automatic logic [15:0] wr_item(input logic [3:0] n);
        logic [15:0] v;
        v = {sweep_pkg::ADDR_CTRL, sweep_pkg::CMD_START, 4'h0};
        case (n)
            4'd0: v = {sweep_pkg::ADDR_START_HI,  i_start_code[23:16]};
            4'd1: v = {sweep_pkg::ADDR_START_MID, i_start_code[15:8]};
            4'd2: v = {sweep_pkg::ADDR_START_LO,  i_start_code[7:0]};
            4'd3: v = {sweep_pkg::ADDR_STEP_HI,   i_step_code[23:16]};
            4'd4: v = {sweep_pkg::ADDR_STEP_MID,  i_step_code[15:8]};
            4'd5: v = {sweep_pkg::ADDR_STEP_LO,   i_step_code[7:0]};
            4'd6: v = {sweep_pkg::ADDR_COUNT_HI,  7'h00, i_point_count[8]};
            4'd7: v = {sweep_pkg::ADDR_COUNT_LO,  i_point_count[7:0]};
            4'd8: v = {sweep_pkg::ADDR_SETTLE_HI, 7'h00, i_settle_cycles[8]};
            4'd9: v = {sweep_pkg::ADDR_SETTLE_LO, i_settle_cycles[7:0]};
            default: v = {sweep_pkg::ADDR_CTRL, sweep_pkg::CMD_START, 4'h0};
        endcase
        return v;
    endfunction

    assign item = wr_item(idx_ff);

    // ------------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= H_IDLE;
            idx_ff   <= 4'h0;
            pend_ff  <= 1'b0;
            req_ff   <= 1'b0;
            wr_ff    <= 1'b0;
            addr_ff  <= 8'h00;
            wdata_ff <= 8'h00;
            res_ff   <= 32'h00000000;
            valid_ff <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            req_ff   <= 1'b0;
            valid_ff <= 1'b0;
            done_ff  <= 1'b0;
            if (pend_ff) begin
                if (bus.ack) begin
                    pend_ff <= 1'b0;
                    case (state_ff)
                        H_WRITE: begin
                            if (idx_ff == 4'(sweep_pkg::WR_ITEMS - 1)) begin
                                state_ff <= H_POLL;
                            end
                            idx_ff <= idx_ff + 4'h1;
                        end
                        H_POLL: begin
                            if (bus.rdata[sweep_pkg::STAT_VALID]) begin
                                state_ff <= H_READ;
                                idx_ff   <= 4'h0;
                            end else if (bus.rdata[sweep_pkg::STAT_DONE]) begin
                                state_ff <= H_FIN;
                            end
                        end
                        H_READ: begin
                            // read both results before next point
                            res_ff <= {res_ff[23:0], bus.rdata};
                            idx_ff <= idx_ff + 4'h1;
                            if (idx_ff == 4'h3) begin
                                state_ff <= H_POLL;
                                valid_ff <= 1'b1;
                            end
                        end
                        default: begin
                            state_ff <= state_ff;
                        end
                    endcase
                end
            end else begin
                case (state_ff)
                    H_IDLE: begin
                        if (i_go) begin
                            state_ff <= H_WRITE;
                            idx_ff   <= 4'h0;
                        end
                    end
                    H_WRITE: begin
                        req_ff   <= 1'b1;
                        pend_ff  <= 1'b1;
                        wr_ff    <= 1'b1;
                        addr_ff  <= item[15:8];
                        wdata_ff <= item[7:0];
                    end
                    H_POLL: begin
                        req_ff  <= 1'b1;
                        pend_ff <= 1'b1;
                        wr_ff   <= 1'b0;
                        addr_ff <= sweep_pkg::ADDR_STATUS;
                    end
                    H_READ: begin
                        req_ff  <= 1'b1;
                        pend_ff <= 1'b1;
                        wr_ff   <= 1'b0;
                        addr_ff <= sweep_pkg::ADDR_REAL_HI + {6'h00, idx_ff[1:0]};
                    end
                    default: begin
                        state_ff <= H_IDLE;
                        done_ff  <= 1'b1;
                    end
                endcase
            end
        end
    end

    assign bus.req        = req_ff;
    assign bus.wr         = wr_ff;
    assign bus.addr       = addr_ff;
    assign bus.wdata      = wdata_ff;
    assign o_busy         = (state_ff != H_IDLE);
    assign o_result_real  = res_ff[31:16];
    assign o_result_imag  = res_ff[15:0];
    assign o_result_valid = valid_ff;
    assign o_sweep_done   = done_ff;

endmodule // sweep_host

// ---- sweep_sva.sv ----
// sweep_sva: checks on the sweep register link
// assumes: bench instantiates it beside the link interface
`timescale 1ns/1ps
module sweep_sva (
    input wire logic       i_clk_sys,
    input wire logic       i_rst_n,
    input wire logic       req,
    input wire logic       wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire wq = req && wr;
    wire rq = req && !wr;
    ack_after_req_a: assert property (req |=> ack && !req ##1 !ack)
        else $error("link answer missing or stretched");
    start_order_a: assert property (wq && addr == 8'h82 |-> ##3
        wq && addr == 8'h83 ##3 wq && addr == 8'h84)
        else $error("start code bytes out of order");
    step_order_a: assert property (wq && addr == 8'h85 |-> ##3
        wq && addr == 8'h86 ##3 wq && addr == 8'h87)
        else $error("step code bytes out of order");
    count_order_a: assert property (wq && addr == 8'h88 |-> ##3
        wq && addr == 8'h89) else $error("count bytes out of order");
    count_width_a: assert property (wq && addr == 8'h88 |->
        wdata[7:1] == 7'h00) else $error("count above nine bits");
    start_cmd_a: assert property (wq && addr == 8'h8b |-> ##3
        wq && addr == 8'h80 && wdata == 8'h30 ##3 rq && addr == 8'h8f)
        else $error("start command or first poll missing");
    status_bits_a: assert property (ack && $past(rq && addr == 8'h8f)
        |-> rdata[7:3] == 5'h00) else $error("status spare bits set");
    result_order_a: assert property (rq && addr == 8'h94 |-> ##3
        rq && addr == 8'h95 ##3 rq && addr == 8'h96 ##3 rq && addr == 8'h97)
        else $error("result bytes out of order");
endmodule // sweep_sva

// ---- impedance_sweep_parameter_regs_bench.sv ----
// bench: host and device joined by the link, front end modelled here
// assumes: 20 MHz clock, active low asynchronous reset
`timescale 1ns/1ps
module impedance_sweep_parameter_regs_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        go = 1'b0;
    logic [23:0] s_code = 24'h0, p_code = 24'h0, f_code, exp_f;
    logic [8:0]  cnt = 9'h0, settle = 9'h0;
    logic        m_done = 1'b0, m_start, busy, h_busy, r_val, s_done;
    logic [15:0] m_re = 16'h0, m_im = 16'h0, r_re, r_im;
    logic [7:0]  wlog [16];
    logic [26:0] ph, ph_prev = 27'h0;
    logic [23:0] f_prev = 24'h0;
    int          pts, error_cnt, n_tests, gap;
    sweep_reg_if bus_if ();
    always #25 clk = ~clk;
    sweep_host u_sweep_host (.i_clk_sys(clk), .i_rst_n(rst_n), .bus(bus_if),
        .i_go(go), .i_start_code(s_code), .i_step_code(p_code),
        .i_point_count(cnt), .i_settle_cycles(settle), .o_busy(h_busy),
        .o_result_real(r_re), .o_result_imag(r_im), .o_result_valid(r_val),
        .o_sweep_done(s_done));
    sweep_device u_sweep_device (.i_clk_sys(clk), .i_rst_n(rst_n),
        .bus(bus_if), .i_meas_done(m_done), .i_meas_real(m_re),
        .i_meas_imag(m_im), .o_meas_start(m_start), .o_dds_phase(ph),
        .o_freq_code(f_code), .o_sweep_busy(busy));
    sweep_sva u_sweep_sva (.i_clk_sys(clk), .i_rst_n(rst_n),
        .req(bus_if.req), .wr(bus_if.wr), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata));
    task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // front end answers each request a cycle later; link writes logged
    always @(negedge clk) begin
        m_done <= m_start;
        if (bus_if.req && bus_if.wr)
            wlog[bus_if.addr[3:0]] <= bus_if.wdata;
        // phase moves by the code once every four clocks
        if (ph !== ph_prev) begin
            chk("phase step", 24'(ph - ph_prev), f_prev);
            if (ph_prev != 27'h0)
                chk("phase pace", 24'(gap), 24'h4);
            gap <= 1;
        end else
            gap <= gap + 1;
        ph_prev <= ph;
        f_prev <= f_code;
        if (m_start) begin
            chk("freq", f_code, exp_f);
            chk("busy", {23'h0, busy}, 24'h1);
            chk("host busy", {23'h0, h_busy}, 24'h1);
            m_re <= pts[15:0];
            m_im <= ~pts[15:0];
            exp_f <= exp_f + p_code;
            pts <= pts + 1;
        end
    end
    task automatic sweep(logic [23:0] s, p, logic [8:0] c, st);
        int n;
        n = 0;
        s_code = s;
        p_code = p;
        cnt = c;
        settle = st;
        exp_f = s;
        pts = 0;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (int k = 0; k < 40000 && s_done !== 1'b1; k++) begin
            @(negedge clk);
            if (r_val === 1'b1) begin
                chk("real", {8'h0, r_re}, {8'h0, n[15:0]});
                chk("imag", {8'h0, r_im}, {8'h0, ~n[15:0]});
                n++;
            end
        end
        if (s_done !== 1'b1) begin
            error_cnt++;
            close_out();
        end
        chk("start", {wlog[2], wlog[3], wlog[4]}, s);
        chk("step", {wlog[5], wlog[6], wlog[7]}, p);
        chk("count", {15'h0, wlog[8][0], wlog[9]}, {15'h0, c});
        chk("settle", {15'h0, wlog[10][0], wlog[11]}, {15'h0, st});
        chk("command", {16'h0, wlog[0]},
            {16'h0, sweep_pkg::CMD_START, 4'h0});
        chk("points", 24'(n), {15'h0, c} + 24'h1);
        @(negedge clk);
        chk("idle", {23'h0, busy}, 24'h0);
        chk("host idle", {23'h0, h_busy}, 24'h0);
    endtask
    task automatic t_single();
        // codes scaled to a quarter of the clock
        sweep(24'h06d3a0, 24'h001179, 9'h000, 9'h000);
        $display("single point sweep done");
    endtask
    task automatic t_multi();
        sweep(24'h400000, 24'h020000, 9'h002, sweep_pkg::SETTLE_USE);
        $display("three point sweep done");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_single();
        t_multi();
        close_out();
    end
endmodule // impedance_sweep_parameter_regs_bench
